//--- rtl/bpi_params.svh
`ifndef BPI_PARAMS_SVH
`define BPI_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define BPI_ARID_W   4
`define BPI_AWID_W   6
`define BPI_ADDR_W   32
`define BPI_CNT_W    9

// ----------------------------------------------------------------
// limits, ids, encodings and reset values
// ----------------------------------------------------------------
`define BPI_MAX_OUT  9'h100
`define BPI_CNT_RST  9'h000
`define BPI_BAR_ID   4'hf
`define BPI_BAR_NORM 2'h0
`define BPI_BAR_MEM  2'h1
`define BPI_BAR_IGN  2'h2
`define BPI_BAR_SYNC 2'h3
`define BPI_RESP_OK  2'h0

`endif

//--- rtl/bpi_pkg.sv
`include "bpi_params.svh"

package bpi_pkg;

  // ----------------------------------------------------------------
  // state of the up/down counter
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`BPI_CNT_W-1:0] cnt;
  } bpi_cnt_st_t;

  // ----------------------------------------------------------------
  // state of the barrier issue controller
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   ar_v;
    logic [`BPI_ARID_W-1:0] ar_id;
    logic [`BPI_ADDR_W-1:0] ar_addr;
    logic [1:0]             ar_bar;
    logic [1:0]             ar_dom;
    logic [2:0]             ar_prot;
    logic                   ar_ord;
    logic                   aw_v;
    logic [`BPI_AWID_W-1:0] aw_id;
    logic [`BPI_ADDR_W-1:0] aw_addr;
    logic [1:0]             aw_bar;
    logic [1:0]             aw_dom;
    logic [2:0]             aw_prot;
    logic                   aw_ord;
    logic                   bar_rdy;
    logic                   rd_rdy;
    logic                   wr_rdy;
    logic                   cache_ok;
    logic [`BPI_CNT_W-1:0]  out_cnt;
    logic                   bar_err;
    logic                   rready;
    logic                   bready;
  } bpi_st_t;

endpackage : bpi_pkg

//--- rtl/bpi_updown.sv
`timescale 1ns/1ps
`default_nettype none
`include "bpi_params.svh"

module bpi_updown (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  inc,
  input  wire logic                  dec,
  output logic      [`BPI_CNT_W-1:0] cnt,
  output logic      [`BPI_CNT_W-1:0] cnt_nxt
);

  bpi_pkg::bpi_cnt_st_t st_r;
  bpi_pkg::bpi_cnt_st_t st_nxt;

  // step by one, inc and dec together cancel
  always_comb begin
    st_nxt = st_r;
    if (inc && !dec) begin
      st_nxt.cnt = st_r.cnt + `BPI_CNT_W'(1);
    end else if (dec && !inc) begin
      st_nxt.cnt = st_r.cnt - `BPI_CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r.cnt <= `BPI_CNT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cnt     = st_r.cnt;
  assign cnt_nxt = st_nxt.cnt;

  // never decrement an empty counter
  chk_no_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
    (dec && !inc) |-> (cnt != `BPI_CNT_RST))
    else $error("counter decremented below zero");

endmodule : bpi_updown

`default_nettype wire

//--- rtl/bpi_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "bpi_params.svh"

module bpi_ctrl (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   bar_req_valid,
  input  wire logic                   bar_req_sync,
  input  wire logic [1:0]             bar_req_domain,
  input  wire logic [2:0]             bar_req_prot,
  output logic                        bar_req_ready,
  input  wire logic                   rd_req_valid,
  input  wire logic                   rd_req_ordered,
  input  wire logic [`BPI_ARID_W-1:0] rd_req_id,
  input  wire logic [`BPI_ADDR_W-1:0] rd_req_addr,
  input  wire logic [1:0]             rd_req_domain,
  input  wire logic [2:0]             rd_req_prot,
  output logic                        rd_req_ready,
  input  wire logic                   wr_req_valid,
  input  wire logic                   wr_req_ordered,
  input  wire logic                   wr_req_snoop,
  input  wire logic [`BPI_AWID_W-1:0] wr_req_id,
  input  wire logic [`BPI_ADDR_W-1:0] wr_req_addr,
  input  wire logic [1:0]             wr_req_domain,
  input  wire logic [2:0]             wr_req_prot,
  output logic                        wr_req_ready,
  output logic                        cache_ok,
  output logic      [`BPI_CNT_W-1:0]  bar_outstanding,
  output logic                        bar_err,
  output logic                        arvalid,
  input  wire logic                   arready,
  output logic      [`BPI_ARID_W-1:0] arid,
  output logic      [`BPI_ADDR_W-1:0] araddr,
  output logic      [1:0]             arbar,
  output logic      [1:0]             ardomain,
  output logic      [2:0]             arprot,
  output logic                        awvalid,
  input  wire logic                   awready,
  output logic      [`BPI_AWID_W-1:0] awid,
  output logic      [`BPI_ADDR_W-1:0] awaddr,
  output logic      [1:0]             awbar,
  output logic      [1:0]             awdomain,
  output logic      [2:0]             awprot,
  input  wire logic                   rvalid,
  input  wire logic [`BPI_ARID_W-1:0] rid,
  input  wire logic [1:0]             rresp,
  input  wire logic                   rlast,
  output logic                        rready,
  input  wire logic                   bvalid,
  input  wire logic [`BPI_AWID_W-1:0] bid,
  input  wire logic [1:0]             bresp,
  output logic                        bready
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [`BPI_AWID_W-1:0] BarIdW =
    {{(`BPI_AWID_W-`BPI_ARID_W){1'b0}}, `BPI_BAR_ID};

  bpi_pkg::bpi_st_t      st_r;
  bpi_pkg::bpi_st_t      st_nxt;
  logic                  bar_acc;
  logic                  rd_acc;
  logic                  wr_acc;
  logic                  rbar;
  logic                  bbar;
  logic                  sh_rd_inc;
  logic                  sh_wr_inc;
  logic                  sh_rd_dec;
  logic                  sh_wr_dec;
  logic                  clear_nxt;
  logic                  snoop_go;
  logic                  bar_go;
  logic [`BPI_CNT_W-1:0] rd_left;
  logic [`BPI_CNT_W-1:0] rd_left_nxt;
  logic [`BPI_CNT_W-1:0] wr_left;
  logic [`BPI_CNT_W-1:0] wr_left_nxt;
  logic [`BPI_CNT_W-1:0] sh_rd;
  logic [`BPI_CNT_W-1:0] sh_rd_nxt;
  logic [`BPI_CNT_W-1:0] sh_wr;
  logic [`BPI_CNT_W-1:0] sh_wr_nxt;
  logic [`BPI_CNT_W-1:0] max_nxt;

  // ----------------------------------------------------------------
  // handshakes and response classification
  // ----------------------------------------------------------------
  assign bar_acc = bar_req_valid && st_r.bar_rdy;
  assign rd_acc  = rd_req_valid && st_r.rd_rdy;
  assign wr_acc  = wr_req_valid && st_r.wr_rdy;
  assign rbar = rvalid && st_r.rready && (rid == `BPI_BAR_ID) && (rd_left != `BPI_CNT_RST);
  assign bbar = bvalid && st_r.bready && (bid == BarIdW) && (wr_left != `BPI_CNT_RST);
  // normal traffic that borrows the barrier id
  assign sh_rd_inc = rd_acc && (rd_req_id == `BPI_BAR_ID);
  assign sh_wr_inc = wr_acc && (wr_req_id == BarIdW);
  assign sh_rd_dec = rvalid && st_r.rready && rlast && (rid == `BPI_BAR_ID)
                     && (rd_left == `BPI_CNT_RST);
  assign sh_wr_dec = bvalid && st_r.bready && (bid == BarIdW) && (wr_left == `BPI_CNT_RST);

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  // halves still owed an answer per channel
  bpi_updown u_rd_left (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .inc     (bar_acc),
    .dec     (rbar),
    .cnt     (rd_left),
    .cnt_nxt (rd_left_nxt)
  );
  bpi_updown u_wr_left (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .inc     (bar_acc),
    .dec     (bbar),
    .cnt     (wr_left),
    .cnt_nxt (wr_left_nxt)
  );
  bpi_updown u_sh_rd (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .inc     (sh_rd_inc),
    .dec     (sh_rd_dec),
    .cnt     (sh_rd),
    .cnt_nxt (sh_rd_nxt)
  );
  bpi_updown u_sh_wr (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .inc     (sh_wr_inc),
    .dec     (sh_wr_dec),
    .cnt     (sh_wr),
    .cnt_nxt (sh_wr_nxt)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // slots, grants and status
  always_comb begin
    st_nxt = st_r;
    // a pair is live while either channel owes an answer
    max_nxt   = (rd_left_nxt > wr_left_nxt) ? rd_left_nxt : wr_left_nxt;
    clear_nxt = (max_nxt == `BPI_CNT_RST);
    if (st_r.ar_v && arready) begin
      st_nxt.ar_v = 1'b0;
    end
    if (st_r.aw_v && awready) begin
      st_nxt.aw_v = 1'b0;
    end
    // both halves loaded from one request
    if (bar_acc) begin
      st_nxt.ar_v    = 1'b1;
      st_nxt.ar_id   = `BPI_BAR_ID;
      st_nxt.ar_addr = '0;
      st_nxt.ar_bar  = bar_req_sync ? `BPI_BAR_SYNC : `BPI_BAR_MEM;
      st_nxt.ar_dom  = bar_req_domain;
      st_nxt.ar_prot = bar_req_prot;
      st_nxt.ar_ord  = 1'b0;
      st_nxt.aw_v    = 1'b1;
      st_nxt.aw_id   = BarIdW;
      st_nxt.aw_addr = '0;
      st_nxt.aw_bar  = bar_req_sync ? `BPI_BAR_SYNC : `BPI_BAR_MEM;
      st_nxt.aw_dom  = bar_req_domain;
      st_nxt.aw_prot = bar_req_prot;
      st_nxt.aw_ord  = 1'b0;
    end
    if (rd_acc) begin
      st_nxt.ar_v    = 1'b1;
      st_nxt.ar_id   = rd_req_id;
      st_nxt.ar_addr = rd_req_addr;
      st_nxt.ar_bar  = rd_req_ordered ? `BPI_BAR_NORM : `BPI_BAR_IGN;
      st_nxt.ar_dom  = rd_req_domain;
      st_nxt.ar_prot = rd_req_prot;
      st_nxt.ar_ord  = rd_req_ordered;
    end
    if (wr_acc) begin
      st_nxt.aw_v    = 1'b1;
      st_nxt.aw_id   = wr_req_id;
      st_nxt.aw_addr = wr_req_addr;
      st_nxt.aw_bar  = wr_req_ordered ? `BPI_BAR_NORM : `BPI_BAR_IGN;
      st_nxt.aw_dom  = wr_req_domain;
      st_nxt.aw_prot = wr_req_prot;
      st_nxt.aw_ord  = wr_req_ordered && !wr_req_snoop;
    end
    // snoop writes need only the write slot
    snoop_go = wr_req_valid && wr_req_snoop && !st_nxt.aw_v;
    // next pair only once both slots are empty
    // both halves ready together, no later reads needed
    // no later writes needed for the read half
    bar_go = bar_req_valid && !st_nxt.ar_v && !st_nxt.aw_v && !snoop_go
             && (max_nxt < `BPI_MAX_OUT)
             && (sh_rd_nxt == `BPI_CNT_RST) && (sh_wr_nxt == `BPI_CNT_RST);
    st_nxt.bar_rdy = bar_go;
    // ordered reads and reads reusing the barrier id wait, other unordered ones do not
    st_nxt.rd_rdy = rd_req_valid && !st_nxt.ar_v && !bar_go
                    && (!rd_req_ordered || clear_nxt)
                    && ((rd_req_id != `BPI_BAR_ID) || clear_nxt);
    // snoop write-backs bypass the barrier gate
    st_nxt.wr_rdy = snoop_go
                    || (wr_req_valid && !st_nxt.aw_v && !bar_go
                        && (!wr_req_ordered || clear_nxt)
                        && ((wr_req_id != BarIdW) || clear_nxt));
    // cache gate follows the outstanding state
    st_nxt.cache_ok = clear_nxt;
    st_nxt.out_cnt  = max_nxt;
    st_nxt.bar_err = (rbar && ((rresp != `BPI_RESP_OK) || !rlast))
                     || (bbar && (bresp != `BPI_RESP_OK));
    st_nxt.rready = 1'b1;
    st_nxt.bready = 1'b1;
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bar_req_ready   = st_r.bar_rdy;
  assign rd_req_ready    = st_r.rd_rdy;
  assign wr_req_ready    = st_r.wr_rdy;
  assign cache_ok        = st_r.cache_ok;
  assign bar_outstanding = st_r.out_cnt;
  assign bar_err         = st_r.bar_err;
  assign arvalid         = st_r.ar_v;
  assign arid            = st_r.ar_id;
  assign araddr          = st_r.ar_addr;
  assign arbar           = st_r.ar_bar;
  assign ardomain        = st_r.ar_dom;
  assign arprot          = st_r.ar_prot;
  assign awvalid         = st_r.aw_v;
  assign awid            = st_r.aw_id;
  assign awaddr          = st_r.aw_addr;
  assign awbar           = st_r.aw_bar;
  assign awdomain        = st_r.aw_dom;
  assign awprot          = st_r.aw_prot;
  assign rready          = st_r.rready;
  assign bready          = st_r.bready;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_bar_taken;
    bar_req_valid && bar_req_ready;
  endsequence

  sequence seq_pair_shown;
    arvalid && awvalid && arbar[0] && awbar[0];
  endsequence

  chk_pair_issue: assert property (seq_bar_taken |=> seq_pair_shown)
    else $error("barrier halves not presented together");

  chk_pair_attr: assert property (seq_bar_taken |=> (arbar == awbar)
      && (ardomain == awdomain) && (arprot == awprot))
    else $error("barrier halves differ in attributes");

  chk_id_pad: assert property (seq_bar_taken |=> (awid == BarIdW)
      && (arid == `BPI_BAR_ID))
    else $error("write barrier id not zero-extended");

  chk_max_out: assert property (bar_outstanding <= `BPI_MAX_OUT)
    else $error("too many barriers outstanding");

  chk_resp_count: assert property ((bbar && !bar_acc) |=>
      (wr_left == $past(wr_left) - `BPI_CNT_W'(1)))
    else $error("write barrier answer not counted");

  chk_ordered_gate: assert property ((($rose(arvalid) && st_r.ar_ord)
      || ($rose(awvalid) && st_r.aw_ord)) |-> ($past(rd_left) == `BPI_CNT_RST)
      && ($past(wr_left) == `BPI_CNT_RST))
    else $error("ordered access passed an outstanding barrier");

  // cache gate drops when a barrier is taken
  chk_cache_gate: assert property (seq_bar_taken |=> !cache_ok ##1 !cache_ok)
    else $error("cache access allowed during barrier");

  chk_snoop_flow: assert property ((wr_req_valid && wr_req_snoop && !awvalid
      && !wr_req_ready && !(bar_req_valid && bar_req_ready)) |=> wr_req_ready)
    else $error("snoop write held back");

  chk_err_flag: assert property ((bbar && (bresp != `BPI_RESP_OK)) |=> bar_err)
    else $error("bad barrier response not flagged");

  // barrier id not reused while normal one is live
  chk_shared_id: assert property ((seq_bar_taken) |-> (sh_rd == `BPI_CNT_RST)
      && (sh_wr == `BPI_CNT_RST))
    else $error("barrier issued with shared id live");

endmodule : bpi_ctrl

`default_nettype wire

//--- dv/bpi_ic_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "bpi_params.svh"

module bpi_ic_model (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   ar_stall,
  input  wire logic                   hold_r,
  input  wire logic                   hold_b,
  input  wire logic                   bad_resp,
  input  wire logic                   arvalid,
  input  wire logic [`BPI_ARID_W-1:0] arid,
  output logic                        arready,
  input  wire logic                   awvalid,
  input  wire logic [`BPI_AWID_W-1:0] awid,
  output logic                        awready,
  output logic                        rvalid,
  output logic      [`BPI_ARID_W-1:0] rid,
  output logic      [1:0]             rresp,
  output logic                        rlast,
  input  wire logic                   rready,
  output logic                        bvalid,
  output logic      [`BPI_AWID_W-1:0] bid,
  output logic      [1:0]             bresp,
  input  wire logic                   bready
);
  // ----------------------------------------------------------------
  // address acceptance and pending answers
  // ----------------------------------------------------------------
  logic [`BPI_ARID_W-1:0] rq[$];
  logic [`BPI_AWID_W-1:0] bq[$];

  // write address always open, read address stalls on demand
  assign arready = !ar_stall;
  assign awready = 1'b1;

  // answers per channel in the order the addresses were taken
  always @(posedge mclk) begin
    if (!rst_n) begin
      rq.delete();
      bq.delete();
      {rvalid, rid, rresp, rlast} <= '0;
      {bvalid, bid, bresp} <= '0;
    end else begin
      if (arvalid && arready) rq.push_back(arid);
      if (awvalid && awready) bq.push_back(awid);
      // echoed id, zero code unless bad_resp, last beat; idle lines scrambled
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        {rid, rresp, rlast} <= ~{rid, rresp, rlast};
        void'(rq.pop_front());
      end else if (!rvalid && rq.size() > 0 && !hold_r) begin
        rvalid <= 1'b1;
        rid    <= rq[0];
        rresp  <= bad_resp ? 2'h2 : `BPI_RESP_OK;
        rlast  <= 1'b1;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        {bid, bresp} <= ~{bid, bresp};
        void'(bq.pop_front());
      end else if (!bvalid && bq.size() > 0 && !hold_b) begin
        bvalid <= 1'b1;
        bid    <= bq[0];
        bresp  <= bad_resp ? 2'h2 : `BPI_RESP_OK;
      end
    end
  end
endmodule : bpi_ic_model
`default_nettype wire

//--- dv/barrier_pair_issue_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bpi_params.svh"

module barrier_pair_issue_ctrl_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                   mclk = 1'b0, rst_n = 1'b0;
  logic                   bar_req_valid = 1'b0, bar_req_sync = 1'b0;
  logic                   rd_req_valid = 1'b0, rd_req_ordered = 1'b0;
  logic                   wr_req_valid = 1'b0, wr_req_ordered = 1'b0, wr_req_snoop = 1'b0;
  logic                   ar_stall = 1'b0, hold_r = 1'b0, hold_b = 1'b0, bad_resp = 1'b0;
  logic [1:0]             bar_req_domain = 2'h0, rd_req_domain = 2'h0, wr_req_domain = 2'h0;
  logic [2:0]             bar_req_prot = 3'h0, rd_req_prot = 3'h0, wr_req_prot = 3'h0;
  logic [`BPI_ARID_W-1:0] rd_req_id = 4'h0, arid, rid;
  logic [`BPI_AWID_W-1:0] wr_req_id = 6'h00, awid, bid;
  logic [`BPI_ADDR_W-1:0] rd_req_addr = 32'h0, wr_req_addr = 32'h0, araddr, awaddr;
  logic                   bar_req_ready, rd_req_ready, wr_req_ready, cache_ok, bar_err;
  logic                   arvalid, arready, awvalid, awready, rvalid, rlast, rready;
  logic                   bvalid, bready;
  logic [1:0]             arbar, ardomain, awbar, awdomain, rresp, bresp;
  logic [2:0]             arprot, awprot;
  logic [`BPI_CNT_W-1:0]  bar_outstanding;
  int                     fail_count = 0, n_compared = 0, cycles = 0;

  bpi_ctrl i_dut (.mclk, .rst_n, .bar_req_valid, .bar_req_sync, .bar_req_domain, .bar_req_prot,
    .bar_req_ready, .rd_req_valid, .rd_req_ordered, .rd_req_id, .rd_req_addr, .rd_req_domain,
    .rd_req_prot, .rd_req_ready, .wr_req_valid, .wr_req_ordered, .wr_req_snoop, .wr_req_id,
    .wr_req_addr, .wr_req_domain, .wr_req_prot, .wr_req_ready, .cache_ok, .bar_outstanding,
    .bar_err, .arvalid, .arready, .arid, .araddr, .arbar, .ardomain, .arprot, .awvalid,
    .awready, .awid, .awaddr, .awbar, .awdomain, .awprot, .rvalid, .rid, .rresp, .rlast,
    .rready, .bvalid, .bid, .bresp, .bready);

  bpi_ic_model i_ic (.mclk, .rst_n, .ar_stall, .hold_r, .hold_b, .bad_resp, .arvalid, .arid,
    .arready, .awvalid, .awid, .awready, .rvalid, .rid, .rresp, .rlast, .rready, .bvalid,
    .bid, .bresp, .bready);

  // clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_hi(ref logic s, input string what);
    int n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (s !== 1'b1 && n < 2000);
    chk(what, 1, s);
  endtask : wait_hi

  task automatic send_bar(logic s, logic [1:0] d, logic [2:0] p);
    @(posedge mclk);
    bar_req_valid  <= 1'b1;
    bar_req_sync   <= s;
    bar_req_domain <= d;
    bar_req_prot   <= p;
    wait_hi(bar_req_ready, "bar_req_ready");
    @(posedge mclk);
    bar_req_valid <= 1'b0;
  endtask : send_bar

  task automatic send_rd(logic ord, logic [3:0] id);
    @(posedge mclk);
    rd_req_valid   <= 1'b1;
    rd_req_ordered <= ord;
    rd_req_id      <= id;
    rd_req_addr    <= {24'h0, id, 4'h0};
    rd_req_domain  <= 2'h2;
    rd_req_prot    <= 3'h5;
    wait_hi(rd_req_ready, "rd_req_ready");
    @(posedge mclk);
    rd_req_valid <= 1'b0;
    #1;
    chk("ar attrs", {id, 5'h15}, {arid, ardomain, arprot});
    chk("araddr", {24'h0, id, 4'h0}, araddr);
    chk("arbar", ord ? `BPI_BAR_NORM : `BPI_BAR_IGN, arbar);
  endtask : send_rd

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    @(posedge mclk);
    #1;
    chk("idle outs", 7'h70, {rready, bready, cache_ok, arvalid, awvalid, bar_err, wr_req_ready});
    chk("bar_outstanding", 0, bar_outstanding);
  endtask : t_reset

  task automatic t_pair(logic s, logic [1:0] d, logic [2:0] p);
    logic [1:0] b;
    b = s ? `BPI_BAR_SYNC : `BPI_BAR_MEM;
    send_bar(s, d, p);
    #1;
    chk("both halves valid", 2'h3, {arvalid, awvalid});
    chk("arid", `BPI_BAR_ID, arid);
    chk("awid", {2'h0, `BPI_BAR_ID}, awid);
    chk("ar attrs", {b, d, p}, {arbar, ardomain, arprot});
    chk("aw attrs", {b, d, p}, {awbar, awdomain, awprot});
    chk("bar_outstanding", 1, bar_outstanding);
    chk("cache_ok", 0, cache_ok);
    wait_hi(cache_ok, "cache_ok");
    chk("bar_outstanding", 0, bar_outstanding);
  endtask : t_pair

  task automatic t_order();
    @(posedge mclk);
    hold_b <= 1'b1;
    send_bar(1'b0, 2'h1, 3'h3);
    send_rd(1'b0, 4'h3);
    @(posedge mclk);
    ar_stall <= 1'b1;
    send_rd(1'b0, 4'h4);
    @(posedge mclk);
    wr_req_valid   <= 1'b1;
    wr_req_snoop   <= 1'b1;
    wr_req_ordered <= 1'b1;
    wr_req_id      <= 6'h21;
    wr_req_addr    <= 32'h80;
    wr_req_domain  <= 2'h1;
    wr_req_prot    <= 3'h6;
    wait_hi(wr_req_ready, "wr_req_ready");
    @(posedge mclk);
    wr_req_valid <= 1'b0;
    #1;
    chk("aw attrs", {6'h21, 5'he}, {awid, awdomain, awprot});
    chk("awaddr", 32'h80, awaddr);
    chk("awbar", `BPI_BAR_NORM, awbar);
    @(posedge mclk);
    ar_stall       <= 1'b0;
    rd_req_valid   <= 1'b1;
    rd_req_ordered <= 1'b1;
    rd_req_id      <= 4'h5;
    rd_req_addr    <= 32'h50;
    rd_req_domain  <= 2'h2;
    rd_req_prot    <= 3'h5;
    repeat (12) begin
      @(posedge mclk);
      #1;
      chk("rd_req_ready", 0, rd_req_ready);
    end
    chk("bar_outstanding", 1, bar_outstanding);
    chk("cache_ok", 0, cache_ok);
    @(posedge mclk);
    hold_b <= 1'b0;
    send_rd(1'b1, 4'h5);
    chk("bar_outstanding", 0, bar_outstanding);
  endtask : t_order

  task automatic t_limit();
    @(posedge mclk);
    hold_r <= 1'b1;
    hold_b <= 1'b1;
    repeat (256) send_bar(1'b1, 2'h3, 3'h2);
    @(posedge mclk);
    #1;
    chk("bar_outstanding", `BPI_MAX_OUT, bar_outstanding);
    @(posedge mclk);
    bar_req_valid <= 1'b1;
    repeat (12) begin
      @(posedge mclk);
      #1;
      chk("bar_req_ready", 0, bar_req_ready);
    end
    @(posedge mclk);
    hold_r <= 1'b0;
    hold_b <= 1'b0;
    wait_hi(bar_req_ready, "bar_req_ready");
    @(posedge mclk);
    bar_req_valid <= 1'b0;
    wait_hi(cache_ok, "cache_ok");
    chk("bar_outstanding", 0, bar_outstanding);
  endtask : t_limit

  task automatic t_err();
    @(posedge mclk);
    bad_resp <= 1'b1;
    send_bar(1'b0, 2'h2, 3'h1);
    wait_hi(bar_err, "bar_err");
    @(posedge mclk);
    #1;
    chk("bar_err", 0, bar_err);
  endtask : t_err

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset();
    for (int i = 0; i < 8; i++) t_pair(i[0], i[2:1], i[2:0]);
    t_order();
    t_limit();
    t_err();
    print_verdict();
  end
endmodule : barrier_pair_issue_ctrl_tb
`default_nettype wire
